// >>> sim/dhrs_chk_properties.sv
// Port assertions for the display reset sequencer
`timescale 1ns/100ps
module dhrs_chk (
	input wire       sys_clk,
	input wire       rst_n,
	input wire       hw_reset_in_n,
	input wire       cmd_valid_in,
	input wire [7:0] cmd_data_in,
	input wire       nvm_rd,
	input wire       display_blank,
	input wire       core_reset,
	input wire       cmd_valid_out,
	input wire [7:0] cmd_data_out,
	input wire       ready
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	long_low_a:
	assert property (!hw_reset_in_n[*8] ##1 !hw_reset_in_n[*6] |-> display_blank && !ready)
		else $error("long pulse not taken");
	short_low_a:
	assert property (ready && hw_reset_in_n ##1 !hw_reset_in_n[*4] ##1 hw_reset_in_n |=> ready)
		else $error("spike caused reset");
	hold_spike_a:
	assert property (core_reset && !hw_reset_in_n ##1 hw_reset_in_n[*4] ##1 !hw_reset_in_n
		|=> core_reset[*4]) else $error("spike ended reset");
	load_start_a:
	assert property ($fell(core_reset) |-> ##[0:2] nvm_rd) else $error("no reload read");
	rd_pulse_a:
	assert property (nvm_rd |=> !nvm_rd) else $error("read strobe too long");
	cancel_time_a:
	assert property ($fell(core_reset) |-> ##[1:20] ready) else $error("reload too slow");
	ready_clear_a:
	assert property (ready |-> !display_blank && !core_reset) else $error("blank while ready");
	drop_cmd_a:
	assert property (cmd_valid_in && !ready |=> !cmd_valid_out) else $error("command leaked");
	pass_cmd_a:
	assert property (cmd_valid_in && ready |=> cmd_valid_out && cmd_data_out == $past(cmd_data_in))
		else $error("command lost");
	// Main scenarios reached
	cover property ($fell(core_reset));
	cover property (cmd_valid_out);
	cover property (!ready && cmd_valid_in);
endmodule // dhrs_chk
bind dhrs_reset_seq dhrs_chk chk_u (.*);

// >>> sim/dhrs_nvm_model.sv
// Stored-settings memory model answering reload reads
`timescale 1ns/100ps
module dhrs_nvm_model (
	input wire       sys_clk,
	input wire       nvm_rd,
	input wire [1:0] nvm_addr,
	output wire [7:0] nvm_rdata
);
	reg [7:0] churn_reg = 8'h5a;
	// Word shown while the read strobe stands, churning data otherwise
	assign nvm_rdata = nvm_rd ? 8'ha5 + {6'h00, nvm_addr} : churn_reg;
	always @(posedge sys_clk) churn_reg <= ~churn_reg;
endmodule // dhrs_nvm_model

// >>> sim/tb.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
module tb;
	reg sys_clk, rst_n, hw_reset_in_n, sleep_in_mode, cmd_valid_in;
	reg [7:0] cmd_data_in;
	wire [7:0] nvm_rdata, cmd_data_out;
	wire [1:0] nvm_addr;
	wire [31:0] setting_words;
	wire nvm_rd, display_blank, core_reset, sleep_exit_allowed, cmd_valid_out, ready;
	integer errors = 0, n_checks = 0, cyc = 0, i, s;
	dhrs_reset_seq #(.FILTER_CYC(8), .BLANK_CYC(50), .WAKE_CYC(100)) dut_u (.*);
	dhrs_nvm_model nvm_u (.*);
	task chk(input [31:0] got, input [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function [7:0] exp_word(input integer k);
		exp_word = 8'ha5 + k[7:0];
	endfunction
	initial begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Hang guard
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			errors = errors + 1;
			stop_test;
		end
	end
	initial begin
		i = $urandom(32'he639_b495);
		{rst_n, sleep_in_mode, cmd_valid_in, cmd_data_in} = 11'h000;
		hw_reset_in_n = 1;
		repeat (6) @(negedge sys_clk);
		rst_n = 1;
		// Random commands, each followed by a random short spike
		for (i = 0; i < 8; i = i + 1) begin
			cmd_data_in = 8'($urandom);
			cmd_valid_in = 1;
			@(negedge sys_clk);
			chk(cmd_valid_out, 1);
			chk(cmd_data_out, cmd_data_in);
			hw_reset_in_n = 0;
			repeat (1 + $urandom % 7) @(negedge sys_clk);
			cmd_valid_in = 0;
			hw_reset_in_n = 1;
			@(negedge sys_clk);
		end
		chk(ready, 1);
		// Full reset from sleep, then from active state
		for (s = 1; s >= 0; s = s - 1) begin
			sleep_in_mode = s[0];
			hw_reset_in_n = 0;
			repeat (12) @(negedge sys_clk);
			chk(display_blank, 1);
			cmd_valid_in = 1;
			@(negedge sys_clk);
			cmd_valid_in = 0;
			chk(cmd_valid_out, 0);
			hw_reset_in_n = 1;
			repeat (4) @(negedge sys_clk);
			hw_reset_in_n = 0;
			@(negedge sys_clk);
			chk(core_reset, 1);
			hw_reset_in_n = 1;
			repeat (25) @(negedge sys_clk);
			chk(ready, s);
			repeat (60) @(negedge sys_clk);
			chk(ready, 1);
			for (i = 0; i < 4; i = i + 1) chk(setting_words[8*i+:8], exp_word(i));
		end
		chk(sleep_exit_allowed, 0);
		repeat (80) @(negedge sys_clk);
		chk(sleep_exit_allowed, 1);
		// Host command sent once the post-release wait has run out
		cmd_data_in = 8'($urandom);
		cmd_valid_in = 1;
		@(negedge sys_clk);
		cmd_valid_in = 0;
		chk(cmd_valid_out, 1);
		chk(cmd_data_out, cmd_data_in);
		stop_test;
	end
endmodule // tb

// >>> verilog/dhrs_glitch_filter.v
// Spike filter for the active-low hardware reset pin
`timescale 1ns/100ps
module dhrs_glitch_filter #(
	parameter FILTER_CYC = 875
) (
	input  wire sys_clk,
	input  wire rst_n,
	input  wire raw_in_n,
	output reg  filt_out_n
);
	// Last count before an edge is accepted, cut to the counter width
	localparam integer FILT_LAST_I = FILTER_CYC - 1;
	localparam [15:0]  FILT_LAST   = FILT_LAST_I[15:0];

	reg [15:0] cnt_reg;

	// Output follows input only after it has been steady for FILTER_CYC cycles
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg    <= 16'h0000;
			filt_out_n <= 1'b1;
		end else if (raw_in_n == filt_out_n) begin
			cnt_reg <= 16'h0000; // Glitch ends, count restarts
		end else if (cnt_reg == FILT_LAST) begin
			cnt_reg    <= 16'h0000;
			filt_out_n <= raw_in_n; // Steady long enough, accept edge
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
endmodule // dhrs_glitch_filter

// >>> verilog/dhrs_map.vh
// Timing constants and reset defaults for the display reset sequencer
`ifndef DHRS_MAP_VH
`define DHRS_MAP_VH
`define DHRS_CLK_MHZ          125
`define DHRS_REJECT_US        5
`define DHRS_ACCEPT_US        9
`define DHRS_FILTER_US        7
`define DHRS_LOAD_US          50
`define DHRS_CANCEL_SLEEP_MS  5
`define DHRS_CANCEL_ACTIVE_MS 120
`define DHRS_BLANK_MS         100
`define DHRS_HOST_CMD_MS      5
`define DHRS_HOST_WAKE_MS     120
`define DHRS_FILTER_CYC       (`DHRS_FILTER_US * `DHRS_CLK_MHZ)
`define DHRS_LOAD_CYC         (`DHRS_LOAD_US * `DHRS_CLK_MHZ)
`define DHRS_BLANK_CYC        (`DHRS_BLANK_MS * 1000 * `DHRS_CLK_MHZ)
`define DHRS_CANCEL_SLEEP_CYC (`DHRS_CANCEL_SLEEP_MS * 1000 * `DHRS_CLK_MHZ)
`define DHRS_WAKE_CYC         (`DHRS_HOST_WAKE_MS * 1000 * `DHRS_CLK_MHZ)
`define DHRS_NVM_WORDS        4
`define DHRS_NVM_AW           2
`define DHRS_DEF_WORD         8'h00
`endif

// >>> verilog/dhrs_reset_seq.v
// Hardware reset sequencer: pin filter, settings reload, display blanking
// Notes on behaviour
// - Reject reset pulses under 5us, accept over 9us
// - Same spike filter applies during ongoing reset
// - Reload stored settings after every reset release
// - Cancel interval 5ms sleeping, 120ms active
// - Blank display during reset; restore defaults
`timescale 1ns/100ps
`include "dhrs_map.vh"
module dhrs_reset_seq #(
	parameter FILTER_CYC = `DHRS_FILTER_CYC,
	parameter LOAD_CYC   = `DHRS_LOAD_CYC,
	parameter BLANK_CYC  = `DHRS_BLANK_CYC,
	parameter WAKE_CYC   = `DHRS_WAKE_CYC,
	parameter NVM_WORDS  = `DHRS_NVM_WORDS,
	parameter NVM_AW     = `DHRS_NVM_AW
) (
	input  wire                      sys_clk,
	input  wire                      rst_n,
	input  wire                      hw_reset_in_n,
	input  wire                      sleep_in_mode,
	input  wire                      cmd_valid_in,
	input  wire [7:0]                cmd_data_in,
	input  wire [7:0]                nvm_rdata,
	output reg  [NVM_AW-1:0]         nvm_addr,
	output reg                       nvm_rd,
	output reg  [8*NVM_WORDS-1:0]    setting_words,
	output reg                       display_blank,
	output reg                       core_reset,
	output reg                       sleep_exit_allowed,
	output reg                       cmd_valid_out,
	output reg  [7:0]                cmd_data_out,
	output wire                      ready
);
	localparam [2:0] ST_RUN   = 3'd0;
	localparam [2:0] ST_BLANK = 3'd1;
	localparam [2:0] ST_HOLD  = 3'd2;
	localparam [2:0] ST_LOAD  = 3'd3;
	localparam [2:0] ST_WAKE  = 3'd4;

	// Dwell limits, cut on purpose to the counter width
	localparam integer BLANK_LAST_I = BLANK_CYC - 1;
	localparam integer WAKE_LAST_I  = WAKE_CYC - 1;
	localparam integer NVM_WORDS_I  = NVM_WORDS;
	localparam [31:0]  BLANK_LAST   = BLANK_LAST_I[31:0];
	localparam [31:0]  WAKE_LAST    = WAKE_LAST_I[31:0];
	localparam [NVM_AW:0] NVM_LAST  = NVM_WORDS_I[NVM_AW:0];

	// States in which the host may talk to the device
	function is_ready_st;
		input [2:0] st;
		begin
			is_ready_st = (st == ST_RUN) || (st == ST_WAKE);
		end
	endfunction

	// States in which the core is held in reset
	function is_core_st;
		input [2:0] st;
		begin
			is_core_st = (st == ST_BLANK) || (st == ST_HOLD);
		end
	endfunction

	wire        filt_n;
	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [31:0] cnt_reg;
	reg  [NVM_AW:0] idx_reg;
	reg         rd_pend_reg;
	wire        load_done;
	wire        cmd_take;

	// Filtered view of the reset pin
	dhrs_glitch_filter #(
		.FILTER_CYC (FILTER_CYC)
	) u_filter (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.raw_in_n   (hw_reset_in_n),
		.filt_out_n (filt_n)
	);

	// Commands accepted only in normal running states
	assign ready = is_ready_st(state_reg);

	// All words read and the last one captured
	assign load_done = (idx_reg == NVM_LAST) && !rd_pend_reg;

	// A host byte that the device will act on
	assign cmd_take = cmd_valid_in && ready;

	// Next state selection
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (!filt_n)
					state_next = sleep_in_mode ? ST_HOLD : ST_BLANK;
			end
			ST_BLANK: begin
				if (cnt_reg >= BLANK_LAST)
					state_next = ST_HOLD; // Blank sequence bounded
			end
			ST_HOLD: begin
				if (filt_n)
					state_next = ST_LOAD; // Release starts reload
			end
			ST_LOAD: begin
				if (load_done)
					state_next = ST_WAKE; // Reload well inside 5ms
				else if (!filt_n)
					state_next = ST_HOLD;
			end
			ST_WAKE: begin
				if (!filt_n)
					state_next = sleep_in_mode ? ST_HOLD : ST_BLANK;
				else if (cnt_reg >= WAKE_LAST)
					state_next = ST_RUN;
			end
			default: state_next = ST_RUN;
		endcase
	end

	// State register and dwell counter
	// Each state times itself from zero; the idle wrap in run is harmless
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_RUN;
			cnt_reg   <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg)
				cnt_reg <= 32'h0000_0000;
			else
				cnt_reg <= cnt_reg + 32'h0000_0001;
		end
	end

	// Status flags follow the state being entered, so they line up with it
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			display_blank      <= 1'b0;
			core_reset         <= 1'b0;
			sleep_exit_allowed <= 1'b1;
		end else begin
			// Blank and hold core while reset is in progress
			display_blank <= !is_ready_st(state_next);
			core_reset    <= is_core_st(state_next);
			// Sleep exit gated until wake wait has run out
			sleep_exit_allowed <= (state_next == ST_RUN);
		end
	end

	// Settings reload from stored memory, index 0 upward
	// Data is taken while the read strobe stands, one word per two cycles
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_reg       <= {(NVM_AW+1){1'b0}};
			rd_pend_reg   <= 1'b0;
			nvm_addr      <= {NVM_AW{1'b0}};
			nvm_rd        <= 1'b0;
			setting_words <= {NVM_WORDS{`DHRS_DEF_WORD}};
		end else begin
			nvm_rd <= 1'b0;
			// Entering hold restarts the reload from scratch
			if (state_next == ST_HOLD) begin
				setting_words <= {NVM_WORDS{`DHRS_DEF_WORD}}; // Defaults restored
				idx_reg       <= {(NVM_AW+1){1'b0}};
				rd_pend_reg   <= 1'b0;
			end else if (state_reg == ST_LOAD) begin
				// One word per read: issue, then capture next cycle
				if (rd_pend_reg) begin
					setting_words[8*nvm_addr +: 8] <= nvm_rdata;
					rd_pend_reg <= 1'b0;
				end else if (idx_reg != NVM_LAST) begin
					nvm_addr    <= idx_reg[NVM_AW-1:0];
					nvm_rd      <= 1'b1;
					rd_pend_reg <= 1'b1;
					idx_reg     <= idx_reg + {{NVM_AW{1'b0}}, 1'b1};
				end
			end
		end
	end

	// Command forwarding gate
	// Bytes that arrive while blanked or reloading are dropped silently
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid_out <= 1'b0;
			cmd_data_out  <= 8'h00;
		end else begin
			cmd_valid_out <= cmd_take;
			if (cmd_take)
				cmd_data_out <= cmd_data_in; // Byte held until next taken one
		end
	end
endmodule // dhrs_reset_seq
